/* logic/qdac_host_ctl.sv */
// How it works
// - Preload: latch-steer low, chip select low, chip select released first.
// - Update: chip-select pulse with all other strobes high copies ranks.
// - Multi preload: chip select rises before latch-steer every time.
// - Long chip select with latch-steer rising first updates outputs together.
// - Per-channel load: latch-steer rises before chip select each channel.
// - Mode update: mode and latch-steer low, chip select low, steer up, chip up.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module qdac_host_ctl
   import qdac_pkg::*;
#(
   parameter int unsigned DW = qdac_pkg::DATA_W
) (
   // Clock, reset, enable
   input  wire logic                   sys_clk_i,
   input  wire logic                   nrst_i,
   input  wire logic                   clk_en_i,
   // APB slave
   input  wire qdac_pkg::qdac_apb_req_s apb_i,
   output var  logic [31:0]            prdata_o,
   output var  logic                   pready_o,
   output var  logic                   pslverr_o,
   // Converter pins
   output var  qdac_pkg::qdac_pins_s   pins_o,
   output var  logic [DW-1:0]          data_o,
   output var  logic                   data_oe_o,
   input  wire logic                   busy_ext_i
);
   import qdac_pkg::*;

   typedef enum logic [2:0] {
      QDAC_ST_IDLE  = 3'h0,
      QDAC_ST_SETUP = 3'h1,
      QDAC_ST_CSLOW = 3'h2,
      QDAC_ST_LSUP  = 3'h3,
      QDAC_ST_CSUP  = 3'h4,
      QDAC_ST_HOLD  = 3'h5
   } qdac_st_e;

   logic            rst_meta_q;
   logic            rst_n;
   logic            ext_busy_s;
   qdac_st_e        st_q;
   qdac_cmd_e       cmd_q;
   logic [ADDR_W-1:0] chan_q;
   logic [DW-1:0]   data_q;
   logic [MODE_W-1:0] mode_q;
   logic            dev_rst_q;
   logic            go_q;
   logic            busy_q;
   logic [7:0]      done_cnt_q;
   logic            tmr_load;
   logic [CNT_W-1:0] tmr_val;
   logic            tmr_done;
   logic            wr_acc;
   logic            rd_acc;
   logic            mapped;
   logic            ls_first;
   logic            is_mode;

   // Reset released through two flops; asynchronous assert only
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // Optional external busy pin crosses into our clock
   qdac_sync u_busy_sync (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (rst_n),
      .en_i      (clk_en_i),
      .d_i       (busy_ext_i),
      .q_o       (ext_busy_s)
   );

   // Strobe-width timer shared by all phases
   qdac_timer #(.W(CNT_W)) u_tmr (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n),
      .en_i      (clk_en_i),
      .load_i    (tmr_load),
      .count_i   (tmr_val),
      .done_o    (tmr_done)
   );

   // APB decode; zero wait states, so access phase completes at once
   assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite;
   assign rd_acc = apb_i.psel && apb_i.penable && !apb_i.pwrite;
   assign mapped = (apb_i.paddr == OFF_CTRL) || (apb_i.paddr == OFF_DATA) ||
                   (apb_i.paddr == OFF_MODE) || (apb_i.paddr == OFF_STATUS);

   // Register writes; a go while busy is refused
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q     <= QDAC_CMD_LOAD_UPD;
         chan_q    <= '0;
         data_q    <= '0;
         mode_q    <= '0;
         dev_rst_q <= 1'b0;
         go_q      <= 1'b0;
      end else if (clk_en_i) begin
         go_q <= 1'b0;
         if (wr_acc) begin
            unique case (apb_i.paddr)
               OFF_CTRL: begin
                  // A running sequence keeps its command and channel
                  if (!busy_q) begin
                     cmd_q  <= qdac_cmd_e'(apb_i.pwdata[CTRL_CMD_LSB +: CTRL_CMD_W]);
                     chan_q <= apb_i.pwdata[CTRL_CH_LSB +: ADDR_W];
                  end
                  dev_rst_q <= apb_i.pwdata[CTRL_RST_BIT];
                  go_q      <= apb_i.pwdata[CTRL_GO_BIT] && !busy_q;
               end
               OFF_DATA: data_q <= apb_i.pwdata[DW-1:0];
               OFF_MODE: mode_q <= apb_i.pwdata[MODE_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // APB answer registered; outputs come from flops
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prdata_o  <= '0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else if (clk_en_i) begin
         pready_o  <= apb_i.psel && !apb_i.penable;
         pslverr_o <= apb_i.psel && !apb_i.penable && !mapped;
         prdata_o  <= '0;
         if (apb_i.psel && !apb_i.penable && !apb_i.pwrite) begin
            unique case (apb_i.paddr)
               OFF_CTRL:   prdata_o <= 32'({chan_q, 1'b0, cmd_q, 2'b00,
                                            dev_rst_q, 1'b0});
               OFF_DATA:   prdata_o <= 32'(data_q);
               OFF_MODE:   prdata_o <= 32'(mode_q);
               OFF_STATUS: prdata_o <= {16'h0000, done_cnt_q, 6'h00,
                                        ext_busy_s, busy_q};
               default:    prdata_o <= '0;
            endcase
         end
      end
   end

   // Mode commands carry mode word; latch-steer order picks update or preload
   assign is_mode  = (cmd_q == QDAC_CMD_MODE_UPD) || (cmd_q == QDAC_CMD_MODE_PRE);
   assign ls_first = (cmd_q == QDAC_CMD_LOAD_UPD) || (cmd_q == QDAC_CMD_MODE_UPD);

   // Sequencer for the pin strobes
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q       <= QDAC_ST_IDLE;
         busy_q     <= 1'b0;
         done_cnt_q <= '0;
         pins_o     <= PINS_IDLE;
         data_o     <= '0;
         data_oe_o  <= 1'b0;
         tmr_load   <= 1'b0;
         tmr_val    <= '0;
      end else if (clk_en_i) begin
         tmr_load       <= 1'b0;
         pins_o.reset_n <= !dev_rst_q;
         unique case (st_q)
            QDAC_ST_IDLE: begin
               if (go_q && !dev_rst_q) begin
                  busy_q <= 1'b1;
                  st_q   <= QDAC_ST_SETUP;
                  pins_o.channel_addr <= chan_q;
                  data_oe_o           <= 1'b1;
                  data_o <= is_mode ? {mode_q, {NIB_W{1'b0}}} : data_q;
                  if (cmd_q == QDAC_CMD_UPDATE) begin
                     pins_o.latch_steer_n <= 1'b1;
                     pins_o.mode_strobe_n <= 1'b1;
                  end else begin
                     pins_o.latch_steer_n <= 1'b0;
                     pins_o.mode_strobe_n <= !is_mode;
                  end
               end
            end
            QDAC_ST_SETUP: begin
               pins_o.cs_n <= 1'b0;
               tmr_load    <= 1'b1;
               tmr_val     <= CW_CNT;
               st_q        <= QDAC_ST_CSLOW;
            end
            QDAC_ST_CSLOW: begin
               if (tmr_done) begin
                  tmr_load <= 1'b1;
                  tmr_val  <= HOLD_CNT;
                  if (ls_first && cmd_q != QDAC_CMD_UPDATE) begin
                     pins_o.latch_steer_n <= 1'b1;
                     st_q <= QDAC_ST_LSUP;
                  end else begin
                     pins_o.cs_n <= 1'b1;
                     st_q <= QDAC_ST_CSUP;
                  end
               end
            end
            QDAC_ST_LSUP: begin
               if (tmr_done) begin
                  pins_o.cs_n <= 1'b1;
                  tmr_load    <= 1'b1;
                  tmr_val     <= LH_CNT;
                  st_q        <= QDAC_ST_HOLD;
               end
            end
            QDAC_ST_CSUP: begin
               if (tmr_done) begin
                  pins_o.latch_steer_n <= 1'b1;
                  tmr_load <= 1'b1;
                  tmr_val  <= LH_CNT;
                  st_q     <= QDAC_ST_HOLD;
               end
            end
            QDAC_ST_HOLD: begin
               if (tmr_done) begin
                  pins_o.mode_strobe_n <= 1'b1;
                  pins_o.channel_addr  <= '0;
                  data_oe_o  <= 1'b0;
                  busy_q     <= 1'b0;
                  done_cnt_q <= done_cnt_q + 8'h01;
                  st_q       <= QDAC_ST_IDLE;
               end
            end
            default: st_q <= QDAC_ST_IDLE;
         endcase
      end
   end

   // Checks on the pin sequence
   // chip select high before steer rises on preload
   a_preload_order: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      (st_q == QDAC_ST_CSUP && cmd_q != QDAC_CMD_UPDATE) |->
      pins_o.cs_n && !pins_o.latch_steer_n)
      else $error("steer rose before chip select on preload");
   a_update_strobes: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      (!pins_o.cs_n && cmd_q == QDAC_CMD_UPDATE) |->
      pins_o.latch_steer_n && pins_o.mode_strobe_n && pins_o.pass_through_n)
      else $error("update pulse with a strobe low");
   a_steer_first: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      (st_q == QDAC_ST_LSUP) |-> !pins_o.cs_n && pins_o.latch_steer_n)
      else $error("chip select rose before steer");
   a_mode_low_nib: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      (!pins_o.mode_strobe_n && !pins_o.cs_n) |-> data_o[NIB_W-1:0] == '0)
      else $error("mode word low nibble not zero");
   a_cs_width: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      $fell(pins_o.cs_n) |-> !pins_o.cs_n [*2])
      else $error("chip select too short");
   a_data_stable: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      (!pins_o.cs_n && !$past(pins_o.cs_n)) |-> $stable(data_o))
      else $error("data moved under chip select");
   a_steer_before_cs: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      ($fell(pins_o.cs_n) && is_mode) |-> !pins_o.latch_steer_n && !pins_o.mode_strobe_n)
      else $error("mode strobes not low at chip select");
   a_busy_ends: assert property (@(posedge sys_clk_i) disable iff (!rst_n || !clk_en_i)
      $rose(busy_q) |-> ##[1:40] !busy_q)
      else $error("sequence did not finish");
   c_update: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
      $fell(pins_o.cs_n) && cmd_q == QDAC_CMD_UPDATE);
   c_mode: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
      $fell(pins_o.cs_n) && cmd_q == QDAC_CMD_MODE_UPD);
   c_preload: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
      st_q == QDAC_ST_CSUP);
   c_mode_pre: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
      $fell(pins_o.cs_n) && cmd_q == QDAC_CMD_MODE_PRE);
   c_load_upd: cover property (@(posedge sys_clk_i) disable iff (!rst_n)
      st_q == QDAC_ST_LSUP && cmd_q == QDAC_CMD_LOAD_UPD);
   // The device latches whatever the bus shows, so it must be driven under select
   a_bus_driven: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
      !pins_o.cs_n |-> data_oe_o)
      else $error("chip select low with data bus released");
   a_reset_pin: assert property (@(posedge sys_clk_i) disable iff (!rst_n || !clk_en_i)
      $rose(dev_rst_q) |=> !pins_o.reset_n)
      else $error("device reset pin did not follow");
endmodule : qdac_host_ctl
`default_nettype wire

/* common/qdac_pkg.sv */
package qdac_pkg;
   // Data bus width and channel count
   localparam int unsigned DATA_W   = 12;
   localparam int unsigned CHAN_N   = 4;
   localparam int unsigned ADDR_W   = 2;
   localparam int unsigned MODE_W   = 8;
   localparam int unsigned NIB_W    = 4;
   // Mode word sits in the top eight data bits
   localparam int unsigned MODE_LSB = 4;

   // Register offsets on the APB side (byte addresses)
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_DATA   = 8'h04;
   localparam logic [7:0] OFF_MODE   = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_TIMING = 8'h10;

   // Control register fields
   localparam int unsigned CTRL_GO_BIT  = 0;
   localparam int unsigned CTRL_RST_BIT = 1;
   localparam int unsigned CTRL_CMD_LSB = 4;
   localparam int unsigned CTRL_CMD_W   = 3;
   localparam int unsigned CTRL_CH_LSB  = 8;

   // Timing: strobe widths in ns, converted to 50 ns cycles
   localparam int unsigned CLK_NS     = 50;
   localparam int unsigned T_CW_NS    = 100;
   localparam int unsigned T_HOLD_NS  = 15;
   localparam int unsigned T_LH_NS    = 70;
   localparam int unsigned CW_CYC     = (T_CW_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned HOLD_CYC   = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned LH_CYC     = (T_LH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned CNT_W      = 4;
   localparam logic [CNT_W-1:0] CW_CNT   = CNT_W'(CW_CYC);
   localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_CYC);
   localparam logic [CNT_W-1:0] LH_CNT   = CNT_W'(LH_CYC);

   // Commands
   typedef enum logic [2:0] {
      QDAC_CMD_LOAD_UPD  = 3'h0,  // First rank of one channel, then all second ranks
      QDAC_CMD_PRELOAD   = 3'h1,  // First rank only
      QDAC_CMD_UPDATE    = 3'h2,  // Copy all first ranks to second ranks
      QDAC_CMD_MODE_UPD  = 3'h3,  // Load mode word and update
      QDAC_CMD_MODE_PRE  = 3'h4   // Load mode first rank only
   } qdac_cmd_e;

   // Pin bundle driven to the converter
   typedef struct packed {
      logic              cs_n;
      logic              latch_steer_n;
      logic              mode_strobe_n;
      logic              pass_through_n;
      logic              read_n;
      logic              reset_n;
      logic [ADDR_W-1:0] channel_addr;
      logic [2:0]        word_part_sel_n;
   } qdac_pins_s;

   localparam qdac_pins_s PINS_IDLE = '{cs_n: 1'b1, latch_steer_n: 1'b1,
      mode_strobe_n: 1'b1, pass_through_n: 1'b1, read_n: 1'b1, reset_n: 1'b1,
      channel_addr: 2'h0, word_part_sel_n: 3'h0};

   // APB request carrier
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } qdac_apb_req_s;
endpackage : qdac_pkg

/* logic/qdac_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module qdac_sync (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic nrst_i,
   input  wire logic en_i,
   // Level in and out
   input  wire logic d_i,
   output var  logic q_o
);
   logic meta_q;

   // Two stages; the first is read only by the second
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= 1'b0;
         q_o    <= 1'b0;
      end else if (en_i) begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule : qdac_sync
`default_nettype wire

/* logic/qdac_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module qdac_timer #(
   parameter int unsigned W = 4
) (
   // Clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         en_i,
   // Load and status
   input  wire logic         load_i,
   input  wire logic [W-1:0] count_i,
   output var  logic         done_o
);
   logic [W-1:0] cnt_q;

   // Down counter; done while zero and not being loaded
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
      end else if (en_i) begin
         if (load_i) begin
            cnt_q <= count_i;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   assign done_o = (cnt_q == '0) && !load_i;
endmodule : qdac_timer
`default_nettype wire

/* testbench/qdac_dev_model.sv */
`timescale 1ns/1ns
`default_nettype none
module qdac_dev_model
   import qdac_pkg::*;
(
   // Pins from the controller
   input  wire qdac_pkg::qdac_pins_s pins_i,
   input  wire logic [11:0]          data_i,
   input  wire logic                 data_oe_i,
   // Latch contents and channel outputs
   output var  logic [3:0][11:0]     first_o,
   output var  logic [3:0][11:0]     second_o,
   output var  logic [3:0][11:0]     chan_out_o,
   output var  logic [7:0]           mode1_o,
   output var  logic [7:0]           mode2_o,
   output var  logic [3:0]           gain_sel_o,
   output var  logic [3:0]           bipolar_o,
   output var  logic                 bad_o
);
   import qdac_pkg::*;

   logic [11:0] last_q;
   logic [11:0] bus_w;

   // A released bus shows the inverse of its last value, never a stale copy
   assign bus_w = data_oe_i ? data_i : ~last_q;

   always @(data_i or data_oe_i) begin
      if (data_oe_i) last_q = data_i;
   end

   initial begin
      first_o = '0;
      second_o = '0;
      mode1_o = '0;
      mode2_o = '0;
      bad_o = 1'b0;
      last_q = '0;
   end

   always @(negedge pins_i.cs_n) begin
      if (!pins_i.read_n || !pins_i.pass_through_n) bad_o = 1'b1;
      else if (pins_i.reset_n) begin
         if (!pins_i.latch_steer_n && !data_oe_i) bad_o = 1'b1;
         if (!pins_i.latch_steer_n && !pins_i.mode_strobe_n) mode1_o = bus_w[11:4];
         else if (!pins_i.latch_steer_n) first_o[pins_i.channel_addr] = bus_w;
         else if (!pins_i.mode_strobe_n) mode2_o = mode1_o;
         else second_o = first_o;
      end
   end

   always @(posedge pins_i.latch_steer_n) begin
      if (!pins_i.cs_n && pins_i.reset_n) begin
         if (!pins_i.mode_strobe_n) mode2_o = mode1_o;
         else second_o = first_o;
      end
   end

   assign chan_out_o = pins_i.reset_n ? second_o : '0;

   assign gain_sel_o = mode2_o[3:0];
   assign bipolar_o  = mode2_o[7:4];
endmodule : qdac_dev_model
`default_nettype wire

/* testbench/qdac_host_ctl_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module qdac_host_ctl_tb_top;
   import qdac_pkg::*;

   typedef struct {
      logic [2:0]  cmd;
      logic [1:0]  ch;
      logic [11:0] val;
      logic [11:0] e1;
      logic [11:0] e2;
   } qdac_row_s;

   logic             sys_clk_i;
   logic             nrst_i;
   logic             clk_en_i;
   logic             busy_ext_i;
   qdac_apb_req_s    apb_q;
   logic [31:0]      prdata_o;
   logic             pready_o;
   logic             pslverr_o;
   qdac_pins_s       pins_o;
   logic [11:0]      data_o;
   logic             data_oe_o;
   logic [3:0][11:0] first_w;
   logic [3:0][11:0] second_w;
   logic [3:0][11:0] out_w;
   logic [7:0]       mode1_w;
   logic [7:0]       mode2_w;
   logic [3:0]       gain_w;
   logic [3:0]       bip_w;
   logic             bad_w;
   logic [31:0]      rd;
   logic             er;
   int               errors;
   int               n_tests;
   int               cyc;
   qdac_row_s        rows [10];

   qdac_host_ctl #(.DW(DATA_W)) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .clk_en_i(clk_en_i), .apb_i(apb_q), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .pins_o(pins_o), .data_o(data_o), .data_oe_o(data_oe_o),
      .busy_ext_i(busy_ext_i));

   qdac_dev_model dev (.pins_i(pins_o), .data_i(data_o), .data_oe_i(data_oe_o),
      .first_o(first_w), .second_o(second_w), .chan_out_o(out_w), .mode1_o(mode1_w),
      .mode2_o(mode2_w), .gain_sel_o(gain_w), .bipolar_o(bip_w), .bad_o(bad_w));

   // Mismatch reporting
   task check(input string name, input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task give_verdict;
      if (errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // One APB transfer; entered just after a rising edge, leaves one idle cycle
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      apb_q.psel <= 1'b1;
      apb_q.penable <= 1'b0;
      apb_q.pwrite <= wr;
      apb_q.paddr <= a;
      apb_q.pwdata <= wd;
      @(posedge sys_clk_i);
      apb_q.penable <= 1'b1;
      // Wait for pready at a rising edge; only the bench timeout ends this
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'b1);
      check("pready wait", n, 48'h1);
      rd = prdata_o;
      er = pslverr_o;
      apb_q.psel <= 1'b0;
      apb_q.penable <= 1'b0;
      @(posedge sys_clk_i);
   endtask : apb

   // Start a pin sequence and poll busy until it clears
   task run_cmd(input logic [2:0] cmd, input logic [1:0] ch);
      int n;
      n = 0;
      apb(1'b1, OFF_CTRL, {22'h0, ch, 1'b0, cmd, 4'h1});
      repeat (2) @(posedge sys_clk_i);
      do begin
         apb(1'b0, OFF_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 40);
      check("busy", {47'h0, rd[0]}, 48'h0);
   endtask : run_cmd

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   // Cut a hang short
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         give_verdict();
      end
   end

   initial begin
      nrst_i = 1'b0;
      clk_en_i = 1'b1;
      busy_ext_i = 1'b0;
      apb_q = '0;
      rows = '{'{3'h0, 2'h0, 12'habc, 12'habc, 12'habc}, '{3'h1, 2'h1, 12'h123, 12'h123, 12'h000},
         '{3'h1, 2'h2, 12'h456, 12'h456, 12'h000}, '{3'h2, 2'h1, 12'h000, 12'h123, 12'h123},
         '{3'h0, 2'h3, 12'hfff, 12'hfff, 12'hfff}, '{3'h0, 2'h2, 12'h001, 12'h001, 12'h001},
         '{3'h4, 2'h0, 12'h05a, 12'h05a, 12'h000}, '{3'h3, 2'h0, 12'h0a5, 12'h0a5, 12'h0a5},
         '{3'h4, 2'h0, 12'h03c, 12'h03c, 12'h0a5}, '{3'h3, 2'h0, 12'h03c, 12'h03c, 12'h03c}};
      repeat (8) @(posedge sys_clk_i);
      check("idle pins", pins_o, PINS_IDLE);
      repeat (8) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      busy_ext_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      // Table of commands with the latch contents they should leave
      for (int i = 0; i < 10; i++) begin
         if (rows[i].cmd >= 3'h3) apb(1'b1, OFF_MODE, {24'h0, rows[i].val[7:0]});
         else apb(1'b1, OFF_DATA, {20'h0, rows[i].val});
         run_cmd(rows[i].cmd, rows[i].ch);
         if (rows[i].cmd >= 3'h3) begin
            check("mode first", mode1_w, rows[i].e1);
            check("mode second", mode2_w, rows[i].e2);
            check("gain", gain_w, rows[i].e2[3:0]);
            check("polarity", bip_w, rows[i].e2[7:4]);
         end else begin
            check("first rank", first_w[rows[i].ch], rows[i].e1);
            check("output", out_w[rows[i].ch], rows[i].e2);
         end
      end
      check("all outputs", out_w, {12'hfff, 12'h001, 12'h123, 12'habc});
      check("all firsts", first_w, {12'hfff, 12'h001, 12'h123, 12'habc});
      check("bus rules", bad_w, 48'h0);
      apb(1'b0, OFF_STATUS, 32'h0);
      check("done count", rd[15:8], 48'ha);
      check("ext busy", rd[1], 48'h1);
      apb(1'b0, OFF_DATA, 32'h0);
      check("data readback", rd, 48'h001);
      apb(1'b0, OFF_MODE, 32'h0);
      check("mode readback", rd, 48'h03c);
      apb(1'b0, OFF_CTRL, 32'h0);
      check("ctrl readback", rd, 48'h030);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped err", er, 48'h1);
      check("unmapped data", rd, 48'h0);
      // Device reset held while a go is refused
      apb(1'b1, OFF_CTRL, 32'h2);
      repeat (2) @(posedge sys_clk_i);
      check("reset outputs", out_w, 48'h0);
      apb(1'b1, OFF_DATA, 32'h777);
      apb(1'b1, OFF_CTRL, 32'h13);
      repeat (20) @(posedge sys_clk_i);
      check("refused go", first_w[0], 48'habc);
      apb(1'b1, OFF_CTRL, 32'h0);
      repeat (3) @(posedge sys_clk_i);
      check("after reset", out_w, {12'hfff, 12'h001, 12'h123, 12'habc});
      // Async reset in the middle of a sequence
      apb(1'b1, OFF_CTRL, 32'h101);
      nrst_i <= 1'b0;
      @(negedge sys_clk_i);
      check("mid reset pins", pins_o, PINS_IDLE);
      check("mid reset oe", data_oe_o, 48'h0);
      // Second release: the cut sequence must not block the next one
      @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      apb(1'b1, OFF_DATA, 32'h555);
      run_cmd(3'h0, 2'h1);
      check("rerun output", out_w[1], 48'h555);
      check("rerun first", first_w[1], 48'h555);
      give_verdict();
   end
endmodule : qdac_host_ctl_tb_top
`default_nettype wire
